// File: prio_level_regs.sv
// interrupt priority level registers with their level resolver
// What this block does
// - each source gets a two-bit level, high register bit is the msb
// - code 00 is lowest, 11 highest, others rank in binary order
// - first low register at B8h, bit addressable, seven source bits
// - first low register resets bits 6 to 0 to zero
// - second low register at F8h, bit addressable, four bits reset zero
// - first high register at B7h, same bit layout, resets to zero
// - reserved bits read as zero; software never writes them as one
// - second high register at F7h, bits 3 to 0 reset to zero
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
module prio_level_regs (
  input  wire logic                              sys_clk,
  input  wire logic                              nrst,
  input  wire prio_pkg::sfr_req_s                sfrReq,
  output logic      [7:0]                        rdData,
  input  wire logic [prio_pkg::NUM_SOURCES-1:0]  pending,
  input  wire logic                              vectorTaken,
  input  wire logic                              serviceDone,
  output prio_pkg::grant_s                       grant,
  output logic      [prio_pkg::NUM_LEVELS-1:0]   levelsInService
);
  import prio_pkg::*;

  // complete block state, registered as one word
  typedef struct packed {
    logic [6:0]            low0;
    logic [6:0]            high0;
    logic [3:0]            low1;
    logic [3:0]            high1;
    logic [7:0]            rdData;
    logic [NUM_LEVELS-1:0] inService;
    grant_s                grant;
  } state_s;

  state_s state_q;
  state_s state_d;
  grant_s arbGrant;

  // register byte as seen by software, reserved bits forced
  function automatic logic [7:0] readByte(input state_s st, input logic [7:0] a);
    logic [7:0] v;
    v = RESERVED_READ;
    unique case (a)
      PRIO_LOW_GROUP0_ADDR:  v = (RESERVED_READ & ~GROUP0_MASK) | {1'b0, st.low0};
      PRIO_HIGH_GROUP0_ADDR: v = (RESERVED_READ & ~GROUP0_MASK) | {1'b0, st.high0};
      PRIO_LOW_GROUP1_ADDR:  v = (RESERVED_READ & ~GROUP1_MASK) | {4'h0, st.low1};
      PRIO_HIGH_GROUP1_ADDR: v = (RESERVED_READ & ~GROUP1_MASK) | {4'h0, st.high1};
      default:               v = RESERVED_READ;
    endcase
    return v;
  endfunction

  // index of the busiest level currently in service
  function automatic logic [1:0] topBusy(input logic [NUM_LEVELS-1:0] busy);
    logic [1:0] t;
    t = 2'h0;
    for (int l = 0; l < NUM_LEVELS; l++) begin
      if (busy[l]) begin
        t = 2'(l);
      end
    end
    return t;
  endfunction

  // resolver looks at the registered levels so a write takes effect next cycle
  level_arbiter u_arb (
    .pending   (pending),
    .levelMsb  ({state_q.high1, state_q.high0}),
    .levelLsb  ({state_q.low1, state_q.low0}),
    .inService (state_q.inService),
    .grant     (arbGrant)
  );

  // next-state logic: register writes, read return, service tracking
  always_comb begin
    logic [2:0] bitSel;
    bitSel  = sfrReq.addr[2:0];
    state_d = state_q;

    // byte writes drop reserved bits, so they always stay clear
    if (sfrReq.wrEn) begin
      unique case (sfrReq.addr)
        PRIO_LOW_GROUP0_ADDR:  state_d.low0  = sfrReq.wrData[6:0];
        PRIO_HIGH_GROUP0_ADDR: state_d.high0 = sfrReq.wrData[6:0];
        PRIO_LOW_GROUP1_ADDR:  state_d.low1  = sfrReq.wrData[3:0];
        PRIO_HIGH_GROUP1_ADDR: state_d.high1 = sfrReq.wrData[3:0];
        default: ;
      endcase
    end

    // single-bit writes reach only the two low registers
    if (sfrReq.bitWrEn) begin
      if (sfrReq.addr[7:3] == BIT_BASE_GROUP0 && bitSel < 3'(GROUP0_BITS)) begin
        state_d.low0[bitSel] = sfrReq.bitVal;
      end
      if (sfrReq.addr[7:3] == BIT_BASE_GROUP1 && bitSel < 3'(GROUP1_BITS)) begin
        state_d.low1[bitSel[1:0]] = sfrReq.bitVal;
      end
    end

    // read data valid only the cycle after the strobe
    state_d.rdData = sfrReq.rdEn ? readByte(state_q, sfrReq.addr) : 8'h00;

    // return from service retires the busiest level first, then a new entry
    if (serviceDone && |state_q.inService) begin
      state_d.inService[topBusy(state_q.inService)] = 1'b0;
    end
    if (vectorTaken && state_q.grant.valid) begin
      state_d.inService[state_q.grant.level] = 1'b1;
    end

    // winner is held off while a vector is being taken or a service returns, to avoid double entry
    state_d.grant = (vectorTaken || serviceDone) ? '0 : arbGrant;

    if (!nrst) begin
      state_d.low0      = GROUP0_RESET;
      state_d.high0     = GROUP0_RESET;
      state_d.low1      = GROUP1_RESET;
      state_d.high1     = GROUP1_RESET;
      state_d.rdData    = 8'h00;
      state_d.inService = '0;
      state_d.grant     = '0;
    end
  end

  // single state register, synchronous reset folded in above
  always_ff @(posedge sys_clk) begin
    state_q <= state_d;
  end

  // outputs straight from the state register
  assign rdData          = state_q.rdData;
  assign grant           = state_q.grant;
  assign levelsInService = state_q.inService;

endmodule : prio_level_regs
`default_nettype wire

// File: prio_pkg.sv
// shared constants and carriers for the interrupt priority level registers
`default_nettype none
package prio_pkg;

  // register offsets in special-function space
  localparam logic [7:0] PRIO_HIGH_GROUP0_ADDR = 8'hB7;
  localparam logic [7:0] PRIO_LOW_GROUP0_ADDR  = 8'hB8;
  localparam logic [7:0] PRIO_HIGH_GROUP1_ADDR = 8'hF7;
  localparam logic [7:0] PRIO_LOW_GROUP1_ADDR  = 8'hF8;

  // bit-addressable windows: upper five address bits pick the byte
  localparam logic [4:0] BIT_BASE_GROUP0 = 5'h17;  // B8h..BFh
  localparam logic [4:0] BIT_BASE_GROUP1 = 5'h1F;  // F8h..FFh

  // implemented bits of each register group
  localparam int         GROUP0_BITS     = 7;
  localparam int         GROUP1_BITS     = 4;
  localparam int         NUM_SOURCES     = GROUP0_BITS + GROUP1_BITS;
  localparam logic [7:0] GROUP0_MASK     = 8'h7F;
  localparam logic [7:0] GROUP1_MASK     = 8'h0F;

  // reset values of the implemented bits
  localparam logic [6:0] GROUP0_RESET    = 7'h00;
  localparam logic [3:0] GROUP1_RESET    = 4'h0;

  // value returned for reserved bits and unmapped addresses
  localparam logic [7:0] RESERVED_READ   = 8'h00;

  // level encoding: msb from the high register, lsb from the low one
  localparam int         LEVEL_BITS      = 2;
  localparam int         NUM_LEVELS      = 4;
  localparam int         SRC_BITS        = 4;

  // source indices, also the fixed polling order (lower index first)
  localparam logic [3:0] SRC_EXT_IRQ0     = 4'h0;
  localparam logic [3:0] SRC_TIMER0       = 4'h1;
  localparam logic [3:0] SRC_EXT_IRQ1     = 4'h2;
  localparam logic [3:0] SRC_TIMER1       = 4'h3;
  localparam logic [3:0] SRC_SERIAL       = 4'h4;
  localparam logic [3:0] SRC_TIMER2       = 4'h5;
  localparam logic [3:0] SRC_COUNTER_ARR  = 4'h6;
  localparam logic [3:0] SRC_BUS_CTRL     = 4'h7;
  localparam logic [3:0] SRC_CONVERTER    = 4'h8;
  localparam logic [3:0] SRC_OVERRUN      = 4'h9;
  localparam logic [3:0] SRC_SERIAL_PERIPH = 4'hA;

  typedef logic [LEVEL_BITS-1:0]  level_t;
  typedef logic [NUM_SOURCES-1:0] srcvec_t;

  // register bus request from the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wrEn;
    logic       rdEn;
    logic       bitWrEn;   // single-bit write, addr is a bit address
    logic       bitVal;
  } sfr_req_s;

  // winner handed to the core's vectoring logic
  typedef struct packed {
    logic                valid;
    logic [SRC_BITS-1:0] src;
    level_t              level;
  } grant_s;

endpackage : prio_pkg
`default_nettype wire

// File: level_arbiter.sv
// picks the pending source with the best level, ties by polling order
`timescale 1ns/1ps
`default_nettype none
module level_arbiter (
  input  wire logic            [prio_pkg::NUM_SOURCES-1:0] pending,
  input  wire logic            [prio_pkg::NUM_SOURCES-1:0] levelMsb,
  input  wire logic            [prio_pkg::NUM_SOURCES-1:0] levelLsb,
  input  wire logic            [prio_pkg::NUM_LEVELS-1:0]  inService,
  output prio_pkg::grant_s                                 grant
);
  import prio_pkg::*;

  // lowest level allowed to interrupt: one above the busiest level
  function automatic logic [2:0] floorLevel(input logic [NUM_LEVELS-1:0] busy);
    logic [2:0] f;
    f = 3'h0;
    for (int l = 0; l < NUM_LEVELS; l++) begin
      if (busy[l]) begin
        f = 3'(l + 1);
      end
    end
    return f;
  endfunction

  // scan levels top down; within each level sources run from the last index down, so the first in polling order is kept
  always_comb begin
    logic [2:0] minLvl;
    level_t     lvl;
    minLvl = floorLevel(inService);
    lvl    = '0;
    grant  = '0;
    for (int l = NUM_LEVELS - 1; l >= 0; l--) begin
      for (int s = NUM_SOURCES - 1; s >= 0; s--) begin
        lvl = {levelMsb[s], levelLsb[s]};
        if (!grant.valid || grant.level == level_t'(l)) begin
          if (pending[s] && lvl == level_t'(l) && {1'b0, lvl} >= minLvl) begin
            grant.src   = SRC_BITS'(s);
            grant.level = lvl;
          end
        end
      end
      if (grant.level == level_t'(l) && pending[grant.src] &&
          {levelMsb[grant.src], levelLsb[grant.src]} == level_t'(l) &&
          {1'b0, level_t'(l)} >= minLvl) begin
        grant.valid = 1'b1;
      end
    end
  end

endmodule : level_arbiter
`default_nettype wire

// File: prio_level_regs_monitor.sv
// port-level assertions for the priority level registers
`timescale 1ns/1ps
`default_nettype none
module prio_level_regs_monitor (
  input wire logic                             sys_clk,
  input wire logic                             nrst,
  input wire prio_pkg::sfr_req_s               sfrReq,
  input wire logic [7:0]                       rdData,
  input wire logic [prio_pkg::NUM_SOURCES-1:0] pending,
  input wire logic                             vectorTaken,
  input wire logic                             serviceDone,
  input wire prio_pkg::grant_s                 grant,
  input wire logic [prio_pkg::NUM_LEVELS-1:0]  levelsInService
);
  import prio_pkg::*;
  logic [NUM_SOURCES-1:0] pendQ;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // last cycle's requests, since grant lags them by one edge
  always_ff @(posedge sys_clk) pendQ <= pending;
  // write of the first low register and its readback
  sequence wrLow0; sfrReq.wrEn && sfrReq.addr == PRIO_LOW_GROUP0_ADDR; endsequence
  sequence rdLow0; sfrReq.rdEn && sfrReq.addr == PRIO_LOW_GROUP0_ADDR; endsequence
  AST_WR_RD: assert property (wrLow0 ##1 rdLow0 |=>
    rdData == ($past(sfrReq.wrData, 2) & GROUP0_MASK)) else $error("low0 readback wrong");
  AST_RD_IDLE: assert property (!$past(sfrReq.rdEn) |-> rdData == 8'h00)
    else $error("read data outside read slot");
  AST_RSV_H0: assert property (sfrReq.rdEn && sfrReq.addr == 8'hB7 |=> !rdData[7])
    else $error("high0 reserved bit set");
  AST_RSV_L1: assert property (sfrReq.rdEn && sfrReq.addr == 8'hF8 |=>
    rdData[7:4] == 4'h0) else $error("low1 reserved bits set");
  AST_GNT_SRC: assert property (grant.valid |-> pendQ[grant.src])
    else $error("grant without request");
  AST_TAKE_CLR: assert property (vectorTaken |=> !grant.valid)
    else $error("grant kept after take");
  AST_TAKE_MARK: assert property (vectorTaken && !serviceDone |=>
    levelsInService[$past(grant.level)]) else $error("taken level not in service");
  AST_IDLE: assert property (pending == '0 [*2] |=> !grant.valid)
    else $error("grant while idle");
  AST_LVL_WIN: assert property (grant.valid |-> (levelsInService >> grant.level) == '0)
    else $error("grant not above service level");
endmodule // prio_level_regs_monitor
bind prio_level_regs prio_level_regs_monitor i_prio_level_regs_monitor (.sys_clk, .nrst,
  .sfrReq, .rdData, .pending, .vectorTaken, .serviceDone, .grant, .levelsInService);
`default_nettype wire

// File: prio_core_model.sv
// behavioural core side: takes vectors and returns from service
`timescale 1ns/1ps
`default_nettype none
module prio_core_model (
  input  wire logic             sys_clk,
  input  wire prio_pkg::grant_s grant,
  input  wire logic             take,
  input  wire logic             done,
  output var logic              vectorTaken = 1'b0,
  output var logic              serviceDone = 1'b0
);
  // one pulse, only on a valid grant; slow when take comes late
  always @(posedge sys_clk) begin
    vectorTaken <= take && grant.valid && !vectorTaken;
    serviceDone <= done;
  end
endmodule // prio_core_model
`default_nettype wire

// File: tb_prio_level_regs.sv
// self-checking bench for the priority level registers
`timescale 1ns/1ps
`default_nettype none
module tb_prio_level_regs;
  import prio_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  sfr_req_s sfrReq = '0;
  logic [NUM_SOURCES-1:0] pending = '0;
  logic take = 1'b0;
  logic done = 1'b0;
  logic [7:0] rdData;
  logic vectorTaken, serviceDone;
  grant_s grant;
  logic [NUM_LEVELS-1:0] levelsInService;
  int nErrors = 0;
  int testsRun = 0;
  int cycles = 0;
  logic [7:0] addrs [4] = '{8'hB7, 8'hB8, 8'hF7, 8'hF8};
  logic [7:0] masks [4] = '{8'h7F, 8'h7F, 8'h0F, 8'h0F};
  prio_level_regs i_prio_level_regs (.sys_clk, .nrst, .sfrReq, .rdData, .pending,
    .vectorTaken, .serviceDone, .grant, .levelsInService);
  prio_core_model i_prio_core_model (.sys_clk, .grant, .take, .done, .vectorTaken,
    .serviceDone);
  initial forever #25 sys_clk = ~sys_clk;
  // hang guard, generous for about 75 cycles of work
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 2000) begin
      nErrors++;
      endOfTest();
    end
  end
  task automatic endOfTest();
    if (nErrors == 0 && testsRun > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string name, logic [7:0] got, logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask
  // strobes stay up so writes and reads can run back to back
  task automatic op(sfr_req_s r);
    @(posedge sys_clk);
    sfrReq <= r;
  endtask
  task automatic idle(int n);
    repeat (n) op('0);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    op('{addr: a, wrData: d, wrEn: 1'b1, default: '0});
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    op('{addr: a, rdEn: 1'b1, default: '0});
    idle(1);
    @(negedge sys_clk);
    chk("rdData", rdData, exp);
  endtask
  // one-cycle take or retire request toward the core model, then n idle cycles
  task automatic pulse(bit retire, int n);
    @(posedge sys_clk);
    if (retire) done <= 1'b1;
    else take <= 1'b1;
    @(posedge sys_clk);
    take <= 1'b0;
    done <= 1'b0;
    idle(n);
    @(negedge sys_clk);
  endtask
  // requests change just after a rising edge, like every other input
  task automatic setPend(logic [NUM_SOURCES-1:0] v);
    @(posedge sys_clk);
    pending <= v;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    idle(1);
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    // software never sets reserved bits, so only implemented bits are written
    foreach (addrs[i]) begin
      wr(addrs[i], masks[i]);
      rd(addrs[i], masks[i]);
    end
    rd(8'h80, 8'h00);
    op('{addr: 8'hBA, bitWrEn: 1'b1, default: '0});
    rd(8'hB8, 8'h7B);
    op('{addr: 8'hF9, bitWrEn: 1'b1, default: '0});
    rd(8'hF8, 8'h0D);
    foreach (addrs[i]) wr(addrs[i], 8'h00);
    pending <= 11'h401;
    // every level code on the last source against source 0 at level 0
    for (int lv = 0; lv < 4; lv++) begin
      wr(PRIO_HIGH_GROUP1_ADDR, {4'h0, lv[1], 3'h0});
      wr(PRIO_LOW_GROUP1_ADDR, {4'h0, lv[0], 3'h0});
      idle(3);
      @(negedge sys_clk);
      chk("grant.valid", {7'h00, grant.valid}, 8'h01);
      chk("grant.src", {4'h0, grant.src}, (lv > 0) ? 8'h0A : 8'h00);
      chk("grant.level", {6'h00, grant.level}, 8'(lv));
    end
    setPend(11'h001);
    idle(2);
    pulse(1'b0, 3);
    chk("levelsInService", {4'h0, levelsInService}, 8'h01);
    setPend(11'h002);
    idle(2);
    @(negedge sys_clk);
    chk("grant.valid", {7'h00, grant.valid}, 8'h00);
    setPend(11'h402);
    idle(2);
    @(negedge sys_clk);
    chk("grant.valid", {7'h00, grant.valid}, 8'h01);
    chk("grant.src", {4'h0, grant.src}, 8'h0A);
    chk("grant.level", {6'h00, grant.level}, 8'h03);
    setPend('0);
    pulse(1'b1, 2);
    chk("levelsInService", {4'h0, levelsInService}, 8'h00);
    endOfTest();
  end
endmodule // tb_prio_level_regs
`default_nettype wire
